// *** design/afi_cmd_core.sv ***
// task-file command core: flush, 48-bit flush, format track, identify device
// assumes master and media logic on the same clock; media pulses done or err once per request
`timescale 1ns/1ps
module afi_cmd_core
#(
   parameter bit          FLUSH_EN      = 1'b1,
   parameter bit          FLUSH_EXT_EN  = 1'b1,
   parameter bit          REMOVABLE     = 1'b0,
   parameter bit          DEV_ID        = 1'b0,
   parameter logic [7:0]  FILL_PATTERN  = 8'hff,
   parameter logic [15:0] CYLINDERS     = 16'h03c0,
   parameter logic [15:0] HEADS         = 16'h0010,
   parameter logic [15:0] SECT_PER_TRK  = 16'h003f,
   parameter logic [31:0] TOTAL_SECTORS = 32'h000ec400,
   // text values are arbitrary
   parameter logic [159:0] SERIAL_TXT   = "          0000000001",
   parameter logic [63:0]  FW_TXT       = "REV 1.00",
   parameter logic [319:0] MODEL_TXT    = "                            FLASH CARD01"
)
(
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   input  wire logic [3:0]              tf_addr,
   input  wire logic [15:0]             tf_wdata,
   input  wire logic                    tf_wr,
   input  wire logic                    tf_rd,
   output logic [15:0]                  tf_rdata,
   output afi_pkg::afi_media_req_s      media_req,
   input  wire logic                    media_done,
   input  wire logic                    media_err,
   input  wire logic [47:0]             media_err_lba
);
   import afi_pkg::*;

   afi_state_e     state_r, state_nxt;
   afi_media_req_s req_r, req_nxt;
   logic [7:0]     feat_r, sc_r, sn_r, cl_r, ch_r, dh_r, mult_r;
   logic [7:0]     hob_sc_r, hob_sn_r, hob_cl_r, hob_ch_r;
   logic [7:0]     word_r;
   logic [47:0]    resume_r;
   logic           err_r, dsc_r;
   logic [15:0]    rdata_r;

   function automatic logic [15:0] id_word(input logic [7:0] i);
      logic [15:0] w;
      w = 16'h0000;
      case (i)
         W_CFG:       w = REMOVABLE ? V_CFG_REMOV : V_CFG_FIXED;
         W_CYL:       w = CYLINDERS;
         W_HEADS:     w = HEADS;
         W_OBS5:      w = V_OBS5;
         W_SPT:       w = SECT_PER_TRK;
         W_TOT_HI:    w = TOTAL_SECTORS[31:16];
         W_TOT_LO:    w = TOTAL_SECTORS[15:0];
         W_BUF_TYPE:  w = V_BUF_TYPE;
         W_BUF_SIZE:  w = V_BUF_SIZE;
         W_W22:       w = V_W22;
         W_MULT_MAX:  w = V_MULT_MAX;
         W_CAPS:      w = V_CAPS;
         W_CAPS2:     w = V_CAPS2;
         W_PIO:       w = V_PIO;
         W_VALID:     w = V_VALID;
         W_CUR_CYL:   w = CYLINDERS;
         W_CUR_HEADS: w = HEADS;
         W_CUR_SPT:   w = SECT_PER_TRK;
         W_CAP_LO:    w = TOTAL_SECTORS[15:0];
         W_CAP_HI:    w = TOTAL_SECTORS[31:16];
         W_MULT_SET:  w = V_MULT_SET | {8'h00, mult_r};
         W_LBA_LO:    w = TOTAL_SECTORS[15:0];
         W_LBA_HI:    w = TOTAL_SECTORS[31:16];
         default:     w = 16'h0000;
      endcase
      // ascii text fields
      // first character in the high byte of each word
      if (i >= W_SER_FIRST && i <= W_SER_LAST)
      begin
         w = SERIAL_TXT[16*(W_SER_LAST - i) +: 16];
      end
      if (i >= W_FW_FIRST && i <= W_FW_LAST)
      begin
         w = FW_TXT[16*(W_FW_LAST - i) +: 16];
      end
      if (i >= W_MOD_FIRST && i <= W_MOD_LAST)
      begin
         w = MODEL_TXT[16*(W_MOD_LAST - i) +: 16];
      end
      return w;
   endfunction

   // decode
   // busy until media answers
   wire bsy      = (state_r == ST_FLUSH) || (state_r == ST_FMT_MEDIA);
   wire drq      = (state_r == ST_FMT_DATA) || (state_r == ST_ID_DATA);
   wire reg_wr   = tf_wr && (state_r == ST_IDLE);
   wire wr_cmd   = reg_wr && (tf_addr == ADR_CMD);
   wire dev_hit  = (dh_r[DH_DEV_BIT] == DEV_ID);
   wire cmd_take = wr_cmd && dev_hit;
   wire op_fl    = tf_wdata[7:0] == OP_FLUSH;
   wire op_fle   = tf_wdata[7:0] == OP_FLUSH_EXT;
   // unsupported flush builds fall to abort
   wire go_flush = cmd_take && ((op_fl && FLUSH_EN) || (op_fle && FLUSH_EXT_EN));
   wire go_fmt   = cmd_take && (tf_wdata[7:0] == OP_FORMAT);
   wire go_id    = cmd_take && (tf_wdata[7:0] == OP_IDENTIFY);
   wire go_abort = cmd_take && !(go_flush || go_fmt || go_id);
   wire data_wr  = tf_wr && (tf_addr == ADR_DATA) && (state_r == ST_FMT_DATA);
   wire data_rd  = tf_rd && (tf_addr == ADR_DATA) && (state_r == ST_ID_DATA);
   wire fin_word = (word_r == LAST_WORD);
   wire media_ev = media_done || media_err;
   wire fl_err   = (state_r == ST_FLUSH) && media_err;
   wire fl_ok    = bsy && media_done && !media_err;
   wire [7:0]  status   = {bsy, 1'b1, 1'b0, dsc_r, drq, 2'b00, err_r};
   wire [7:0]  err_reg  = {5'h00, err_r, 2'b00};
   // start address from head nibble and cylinder bytes
   wire [47:0] fmt_lba  = {20'h00000, dh_r[3:0], ch_r, cl_r, 8'h00};
   // zero count means a full 256
   wire [8:0]  lba_cnt  = (sc_r == 8'h00) ? FULL_COUNT : {1'b0, sc_r};
   wire [8:0]  fmt_cnt  = dh_r[DH_LBA_BIT] ? lba_cnt : SECT_PER_TRK[8:0];
   wire [47:0] resume_n = media_err_lba + 48'h000000000001;

   logic [15:0] rd_val;
   always_comb
   begin
      rd_val = 16'h0000;
      case (tf_addr)
         // parameter words stream on the data port
         ADR_DATA:   rd_val = (state_r == ST_ID_DATA) ? id_word(word_r) : 16'h0000;
         ADR_FEAT:   rd_val = {8'h00, err_reg};
         ADR_SC:     rd_val = {8'h00, sc_r};
         ADR_SN:     rd_val = {8'h00, sn_r};
         ADR_CL:     rd_val = {8'h00, cl_r};
         ADR_CH:     rd_val = {8'h00, ch_r};
         ADR_DH:     rd_val = {8'h00, dh_r};
         ADR_CMD:    rd_val = {8'h00, status};
         ADR_MULT:   rd_val = {8'h00, mult_r};
         ADR_HOB_SN: rd_val = {8'h00, hob_sn_r};
         ADR_HOB_CL: rd_val = {8'h00, hob_cl_r};
         ADR_HOB_CH: rd_val = {8'h00, hob_ch_r};
         default:    rd_val = 16'h0000;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (go_flush)
               state_nxt = ST_FLUSH;
            else if (go_fmt)
               state_nxt = ST_FMT_DATA;
            else if (go_id)
               state_nxt = ST_ID_DATA;
         end
         // stay until media reports done or error
         ST_FLUSH:     state_nxt = media_ev ? ST_IDLE : ST_FLUSH;
         ST_FMT_DATA:  state_nxt = (data_wr && fin_word) ? ST_FMT_MEDIA : ST_FMT_DATA;
         ST_FMT_MEDIA: state_nxt = media_ev ? ST_IDLE : ST_FMT_MEDIA;
         ST_ID_DATA:   state_nxt = (data_rd && fin_word) ? ST_IDLE : ST_ID_DATA;
         default:      state_nxt = ST_IDLE;
      endcase
   end

   always_comb
   begin
      req_nxt = req_r;
      if (go_flush)
      begin
         req_nxt.valid     = 1'b1;
         req_nxt.is_format = 1'b0;
         // extended flush picks up after the last failure
         req_nxt.lba       = op_fle ? resume_r : 48'h000000000000;
         req_nxt.count     = 9'h000;
      end
      else if (data_wr && fin_word)
      begin
         req_nxt.valid     = 1'b1;
         req_nxt.is_format = 1'b1;
         req_nxt.lba       = fmt_lba;
         req_nxt.count     = fmt_cnt;
      end
      else if (media_ev && bsy)
      begin
         req_nxt.valid     = 1'b0;
      end
      req_nxt.pattern = FILL_PATTERN;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_IDLE;
         req_r   <= '0;
         word_r  <= 8'h00;
         rdata_r <= 16'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         req_r   <= req_nxt;
         rdata_r <= tf_rd ? rd_val : 16'h0000;
         if (state_r == ST_IDLE)
            word_r <= 8'h00;
         else if (data_wr || data_rd)
            word_r <= word_r + 8'h01;
      end
   end

   // failing address overrides the command block
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {sn_r, cl_r, ch_r, hob_sn_r, hob_cl_r, hob_ch_r} <= 48'h000000000000;
         {sc_r, hob_sc_r} <= 16'h0000;
      end
      else if (fl_err)
      begin
         {hob_ch_r, hob_cl_r, hob_sn_r, ch_r, cl_r, sn_r} <= media_err_lba;
      end
      else if (reg_wr)
      begin
         // each sector count, sector number or cylinder write pushes the previous byte to the high-order copy
         case (tf_addr)
            ADR_SC:  {hob_sc_r, sc_r} <= {sc_r, tf_wdata[7:0]};
            ADR_SN:  {hob_sn_r, sn_r} <= {sn_r, tf_wdata[7:0]};
            ADR_CL:  {hob_cl_r, cl_r} <= {cl_r, tf_wdata[7:0]};
            ADR_CH:  {hob_ch_r, ch_r} <= {ch_r, tf_wdata[7:0]};
            default: sc_r <= sc_r;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         feat_r <= 8'h00;
         dh_r   <= 8'h00;
         mult_r <= 8'h00;
      end
      else if (reg_wr)
      begin
         if (tf_addr == ADR_FEAT)
            feat_r <= tf_wdata[7:0];
         if (tf_addr == ADR_DH)
            dh_r <= tf_wdata[7:0];
         // host's multiple setting mirrored in word 59
         if (tf_addr == ADR_MULT)
            mult_r <= tf_wdata[7:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         err_r    <= 1'b0;
         dsc_r    <= 1'b1;
         resume_r <= 48'h000000000000;
      end
      else
      begin
         // ready and seek-complete on good completion
         if (go_abort || (bsy && media_err))
            err_r <= 1'b1;
         else if (cmd_take)
            err_r <= 1'b0;
         if (fl_ok || (state_r == ST_ID_DATA && state_nxt == ST_IDLE))
            dsc_r <= 1'b1;
         else if (go_flush || go_fmt)
            dsc_r <= 1'b0;
         if (fl_err)
            resume_r <= resume_n;
         else if (fl_ok && state_r == ST_FLUSH)
            resume_r <= 48'h000000000000;
      end
   end

   assign tf_rdata  = rdata_r;
   assign media_req = req_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   AST_FLUSH_BUSY: assert property (
      (state_r == ST_FLUSH) && !media_ev |=> status[ST_BSY_BIT] && req_r.valid)
      else $error("busy dropped during flush");
   AST_FLUSH_DONE: assert property (
      (state_r == ST_FLUSH) && media_done && !media_err |=>
      status[ST_RDY_BIT] && status[ST_DSC_BIT] && !status[ST_BSY_BIT] && !err_r)
      else $error("flush completion status wrong");
   AST_FLUSH_WAIT: assert property (
      (state_r == ST_FLUSH) && !media_ev |=> (state_r == ST_FLUSH) && !status[ST_DSC_BIT])
      else $error("flush ended before media done");
   AST_UNSUP: assert property (
      cmd_take && ((op_fl && !FLUSH_EN) || (op_fle && !FLUSH_EXT_EN)) |=>
      err_reg[ER_ABRT_BIT] && status[ST_ERR_BIT] && state_r == ST_IDLE)
      else $error("unsupported flush not aborted");
   AST_ERR_LBA: assert property (
      fl_err |=> {hob_ch_r, hob_cl_r, hob_sn_r, ch_r, cl_r, sn_r} == $past(media_err_lba)
      && err_r && state_r == ST_IDLE)
      else $error("failing address not loaded");
   AST_RESUME: assert property (
      fl_err |=> resume_r == $past(media_err_lba) + 48'h000000000001)
      else $error("resume point not after failing sector");
   AST_RESUME_REQ: assert property (
      go_flush && op_fle |=> req_r.lba == $past(resume_r))
      else $error("extended flush did not resume");
   AST_FMT_REQ: assert property (
      data_wr && fin_word |=> req_r.is_format && req_r.valid
      && req_r.lba == {20'h00000, $past(dh_r[3:0]), $past(ch_r), $past(cl_r), 8'h00}
      && req_r.pattern == FILL_PATTERN)
      else $error("format request wrong");
   AST_FMT_DROP: assert property (
      data_wr && !fin_word |=> state_r == ST_FMT_DATA && !req_r.valid)
      else $error("dummy sector word not simply dropped");
   AST_FMT_CNT: assert property (
      data_wr && fin_word && dh_r[DH_LBA_BIT] && sc_r == 8'h00 |=> req_r.count == FULL_COUNT)
      else $error("zero count not 256");
   AST_ID_W0: assert property (
      data_rd && word_r == W_CFG |=> tf_rdata == (REMOVABLE ? V_CFG_REMOV : V_CFG_FIXED))
      else $error("config word wrong");
   AST_ID_W59: assert property (
      data_rd && word_r == W_MULT_SET |=> tf_rdata[7:0] == mult_r)
      else $error("multiple setting not reflected");
   AST_DEV_SEL: assert property (
      wr_cmd && !dev_hit |=> state_r == ST_IDLE && $stable(err_r))
      else $error("command taken for other drive");
   AST_ID_DONE: assert property (
      data_rd && fin_word |=> state_r == ST_IDLE && !status[ST_DRQ_BIT])
      else $error("identify stream did not end after one sector");
   AST_ID_RSVD: assert property (
      data_rd && (word_r == 8'd2 || word_r == 8'd48 || word_r == 8'd52) |=> tf_rdata == 16'h0000)
      else $error("reserved word not zero");
   AST_ID_TOTAL: assert property (
      data_rd && word_r == W_TOT_HI |=> tf_rdata == TOTAL_SECTORS[31:16])
      else $error("total sector upper half wrong");
   AST_ID_CAP: assert property (
      data_rd && word_r == W_CAP_LO |=> tf_rdata == TOTAL_SECTORS[15:0])
      else $error("capacity lower half wrong");
   AST_ID_W47: assert property (
      data_rd && word_r == W_MULT_MAX |=> tf_rdata == V_MULT_MAX)
      else $error("multiple block limit wrong");
   AST_ID_W53: assert property (
      data_rd && word_r == W_VALID |=> tf_rdata == V_VALID)
      else $error("field validity word wrong");
   AST_ID_W49: assert property (
      data_rd && word_r == W_CAPS |=> tf_rdata == V_CAPS)
      else $error("capability word wrong");
   AST_ID_TEXT: assert property (
      data_rd && word_r == W_SER_LAST |=> tf_rdata == SERIAL_TXT[15:0])
      else $error("serial text tail wrong");
   AST_ID_LBA: assert property (
      data_rd && word_r == W_LBA_HI |=> tf_rdata == TOTAL_SECTORS[31:16])
      else $error("lba sector total wrong");

   COV_ABORT:     cover property (go_abort);
   COV_FLUSH_ERR: cover property (fl_err ##[1:50] (go_flush && op_fle));
   COV_FMT:       cover property (go_fmt ##[1:600] (state_r == ST_FMT_MEDIA) ##[1:50] media_done);
   COV_ID:        cover property (go_id ##[256:800] (state_r == ST_IDLE));
endmodule

// *** design/afi_pkg.sv ***
// constants, types and field layout of the flush, format and identify command core
// assumes a single 200 MHz clock domain shared with the task-file master and media logic
//
// Summary of operation
// - Flush opcode finishes writing all pending cache entries before completion.
// - Completion after flush reports ready and seek-complete both set.
// - A build without a flush command aborts that command instead.
// - Busy stays high through the 48-bit flush until done or error.
// - Flush write error aborts and loads 48-bit failing sector address.
// - Repeated 48-bit flush resumes at the sector after the failing one.
// - Format overwrites addressed track with a fixed fill pattern.
// - Host sends one dummy sector after format; device accepts, discards it.
// - Format in LBA mode takes count from sector count, zero meaning 256.
// - Format start address built from drive/head nibble and cylinder bytes.
// - Identify returns the parameter block like a single-sector read.
// - Reserved bits and words of the parameter block read zero.
// - Word 0 reports fixed-disk configuration, removable variant optional.
// - Total sectors in words 7 and 8, upper half first.
// - Current capacity in words 57 and 58, lower half first.
// - Word 47 gives maximum sectors per multiple block.
// - Word 53 flags words 54-58, 64-70 and 88 valid.
// - Word 59 follows the host's current multiple-sector setting.
// - Word 49 advertises DMA, LBA and ready-based flow control.
// - Serial, firmware and model text in ASCII, big-endian bytes per word.
// - Words 60 and 61 hold total LBA-addressable sectors.
package afi_pkg;
   // task-file offsets
   localparam logic [3:0] ADR_DATA   = 4'h0;
   localparam logic [3:0] ADR_FEAT   = 4'h1;
   localparam logic [3:0] ADR_SC     = 4'h2;
   localparam logic [3:0] ADR_SN     = 4'h3;
   localparam logic [3:0] ADR_CL     = 4'h4;
   localparam logic [3:0] ADR_CH     = 4'h5;
   localparam logic [3:0] ADR_DH     = 4'h6;
   localparam logic [3:0] ADR_CMD    = 4'h7;
   localparam logic [3:0] ADR_MULT   = 4'h8;
   localparam logic [3:0] ADR_HOB_SN = 4'h9;
   localparam logic [3:0] ADR_HOB_CL = 4'ha;
   localparam logic [3:0] ADR_HOB_CH = 4'hb;
   // opcodes
   localparam logic [7:0] OP_FLUSH     = 8'he7;
   localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
   localparam logic [7:0] OP_FORMAT    = 8'h50;
   localparam logic [7:0] OP_IDENTIFY  = 8'hec;
   // field positions
   localparam int DH_DEV_BIT  = 4;
   localparam int DH_LBA_BIT  = 6;
   localparam int ST_BSY_BIT  = 7;
   localparam int ST_RDY_BIT  = 6;
   localparam int ST_DSC_BIT  = 4;
   localparam int ST_DRQ_BIT  = 3;
   localparam int ST_ERR_BIT  = 0;
   localparam int ER_ABRT_BIT = 2;
   // sector framing
   localparam logic [7:0] LAST_WORD  = 8'hff;
   localparam logic [8:0] FULL_COUNT = 9'h100;
   // parameter block words
   localparam logic [7:0] W_CFG = 8'd0, W_CYL = 8'd1, W_HEADS = 8'd3, W_OBS5 = 8'd5;
   localparam logic [7:0] W_SPT = 8'd6, W_TOT_HI = 8'd7, W_TOT_LO = 8'd8;
   localparam logic [7:0] W_SER_FIRST = 8'd10, W_SER_LAST = 8'd19;
   localparam logic [7:0] W_BUF_TYPE = 8'd20, W_BUF_SIZE = 8'd21, W_W22 = 8'd22;
   localparam logic [7:0] W_FW_FIRST = 8'd23, W_FW_LAST = 8'd26;
   localparam logic [7:0] W_MOD_FIRST = 8'd27, W_MOD_LAST = 8'd46;
   localparam logic [7:0] W_MULT_MAX = 8'd47, W_CAPS = 8'd49, W_CAPS2 = 8'd50;
   localparam logic [7:0] W_PIO = 8'd51, W_VALID = 8'd53, W_CUR_CYL = 8'd54;
   localparam logic [7:0] W_CUR_HEADS = 8'd55, W_CUR_SPT = 8'd56;
   localparam logic [7:0] W_CAP_LO = 8'd57, W_CAP_HI = 8'd58, W_MULT_SET = 8'd59;
   localparam logic [7:0] W_LBA_LO = 8'd60, W_LBA_HI = 8'd61;
   localparam logic [15:0] V_CFG_FIXED = 16'h045a, V_CFG_REMOV = 16'h848a;
   localparam logic [15:0] V_OBS5 = 16'h0200, V_BUF_TYPE = 16'h0002;
   localparam logic [15:0] V_BUF_SIZE = 16'h0001, V_W22 = 16'h0004;
   localparam logic [15:0] V_MULT_MAX = 16'h8001, V_CAPS = 16'h0f00;
   localparam logic [15:0] V_CAPS2 = 16'h4001, V_PIO = 16'h0200;
   localparam logic [15:0] V_VALID = 16'h0007, V_MULT_SET = 16'h0100;

   typedef enum logic [2:0] {ST_IDLE, ST_FLUSH, ST_FMT_DATA, ST_FMT_MEDIA, ST_ID_DATA} afi_state_e;

   typedef struct packed {
      logic        valid;
      logic        is_format;
      logic [47:0] lba;
      logic [8:0]  count;
      logic [7:0]  pattern;
   } afi_media_req_s;
endpackage

// *** tb/afi_media_model.sv ***
// media side model: answers each job once, with done or error, after a set delay
// assumes one job at a time, request held until answered
`timescale 1ns/1ps
module afi_media_model
(
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   input  wire afi_pkg::afi_media_req_s  media_req,
   input  wire logic [7:0]               lat,
   input  wire logic                     fail,
   input  wire logic [47:0]              fail_lba,
   output logic                          media_done,
   output logic                          media_err,
   output logic [47:0]                   media_err_lba
);
   import afi_pkg::*;

   logic [7:0] cnt_r;
   logic       fired_r;

   // address shows junk outside the error pulse
   assign media_err_lba = media_err ? fail_lba : ~fail_lba;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r      <= 8'h00;
         fired_r    <= 1'b0;
         media_done <= 1'b0;
         media_err  <= 1'b0;
      end
      else if (!media_req.valid)
      begin
         cnt_r      <= 8'h00;
         fired_r    <= 1'b0;
         media_done <= 1'b0;
         media_err  <= 1'b0;
      end
      else if (!fired_r && cnt_r == lat)
      begin
         media_done <= !fail;
         media_err  <= fail;
         fired_r    <= 1'b1;
      end
      else
      begin
         cnt_r      <= cnt_r + 8'h01;
         media_done <= 1'b0;
         media_err  <= 1'b0;
      end
   end
endmodule

// *** tb/afi_cmd_core_tb.sv ***
// self-checking bench for the flush, format and identify command core
// assumes the media model answers every job; a second core is built without flush
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end

module afi_cmd_core_tb;
   import afi_pkg::*;
   logic            clock, arst_n, tf_wr, tf_rd, fail;
   logic [3:0]      tf_addr;
   logic [15:0]     tf_wdata, tf_rdata, nf_rdata, d, nf_d;
   logic [47:0]     media_err_lba, fail_lba;
   logic            media_done, media_err;
   logic [7:0]      lat;
   afi_media_req_s  media_req;
   logic [15:0]     idw [256];
   logic [3:0]      offs [6];
   int              mismatches = 0;
   int              samples_checked = 0;
   int              cyc = 0;

   afi_cmd_core u_afi_cmd_core (.clock(clock), .arst_n(arst_n), .tf_addr(tf_addr),
      .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata),
      .media_req(media_req), .media_done(media_done), .media_err(media_err),
      .media_err_lba(media_err_lba));
   // build without either flush command
   afi_cmd_core #(.FLUSH_EN(1'b0), .FLUSH_EXT_EN(1'b0)) u_afi_cmd_core_nf (.clock(clock),
      .arst_n(arst_n), .tf_addr(tf_addr), .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd),
      .tf_rdata(nf_rdata), .media_req(), .media_done(1'b0), .media_err(1'b0),
      .media_err_lba(48'h0));
   afi_media_model u_afi_media_model (.clock(clock), .arst_n(arst_n), .media_req(media_req),
      .lat(lat), .fail(fail), .fail_lba(fail_lba), .media_done(media_done),
      .media_err(media_err), .media_err_lba(media_err_lba));

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      tf_addr  <= a;
      tf_wdata <= v;
      tf_wr    <= 1'b1;
      @(posedge clock);
      tf_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      tf_addr <= a;
      tf_rd   <= 1'b1;
      @(posedge clock);
      tf_rd   <= 1'b0;
      @(negedge clock);
      d    = tf_rdata;
      nf_d = nf_rdata;
   endtask

   task automatic wait_idle;
      for (int n = 0; n < 300; n++)
      begin
         rd(ADR_CMD);
         if (d[ST_BSY_BIT] === 1'b0)
            return;
      end
      `CHK(1'b0, 1'b1)
   endtask

   task automatic wait_req;
      for (int n = 0; n < 8; n++)
      begin
         @(negedge clock);
         if (media_req.valid === 1'b1)
            return;
      end
      `CHK(1'b0, 1'b1)
   endtask

   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, mismatches);
   endtask

   initial
   begin
      tf_addr  = 4'h0;
      tf_wdata = 16'h0000;
      tf_wr    = 1'b0;
      tf_rd    = 1'b0;
      fail     = 1'b0;
      fail_lba = 48'h123456789abc;
      lat      = 8'd20;
      arst_n   = 1'b0;
      offs     = '{ADR_SN, ADR_CL, ADR_CH, ADR_HOB_SN, ADR_HOB_CL, ADR_HOB_CH};
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      rd(ADR_CMD);
      `CHK(d, 16'h0050)
      test_end("reset");
      wr(ADR_DH, 16'h0010);
      wr(ADR_CMD, {8'h00, OP_IDENTIFY});
      rd(ADR_CMD);
      `CHK(d, 16'h0050)
      test_end("other_drive");
      wr(ADR_DH, 16'h0000);
      wr(ADR_MULT, 16'h0004);
      wr(ADR_CMD, {8'h00, OP_IDENTIFY});
      rd(ADR_CMD);
      `CHK(d, 16'h0058)
      for (int i = 0; i < 256; i++)
      begin
         rd(ADR_DATA);
         idw[i] = d;
      end
      `CHK(idw[0], V_CFG_FIXED)
      `CHK(idw[2], 16'h0000)
      `CHK({idw[7], idw[8]}, 32'h000ec400)
      `CHK({idw[10], idw[19]}, 32'h20203031)
      `CHK({idw[23], idw[46]}, 32'h52453031)
      `CHK(idw[47], 16'h8001)
      `CHK(idw[49], 16'h0f00)
      `CHK(idw[53], 16'h0007)
      `CHK({idw[58], idw[57]}, 32'h000ec400)
      `CHK(idw[59], 16'h0104)
      `CHK({idw[61], idw[60]}, 32'h000ec400)
      rd(ADR_CMD);
      `CHK(d, 16'h0050)
      test_end("identify");
      wr(ADR_CMD, {8'h00, OP_FLUSH});
      wait_req();
      `CHK({media_req.is_format, media_req.lba}, 49'h0)
      rd(ADR_CMD);
      `CHK(d[ST_BSY_BIT], 1'b1)
      `CHK({nf_d[ST_BSY_BIT], nf_d[ST_ERR_BIT]}, 2'b01)
      rd(ADR_FEAT);
      `CHK(nf_d[ER_ABRT_BIT], 1'b1)
      wait_idle();
      `CHK(d, 16'h0050)
      test_end("flush");
      fail = 1'b1;
      lat  = 8'd40;
      wr(ADR_CMD, {8'h00, OP_FLUSH_EXT});
      wait_req();
      repeat (5)
      begin
         rd(ADR_CMD);
         `CHK(d[ST_BSY_BIT], 1'b1)
      end
      wait_idle();
      `CHK(d, 16'h0041)
      rd(ADR_FEAT);
      `CHK(d, 16'h0004)
      for (int k = 0; k < 6; k++)
      begin
         rd(offs[k]);
         `CHK(d, {8'h00, fail_lba[8*k +: 8]})
      end
      fail = 1'b0;
      lat  = 8'd2;
      wr(ADR_CMD, {8'h00, OP_FLUSH_EXT});
      wait_req();
      `CHK(media_req.lba, fail_lba + 48'h1)
      wait_idle();
      `CHK(d, 16'h0050)
      test_end("flush_ext");
      // format issued only here, as a careful host would avoid it
      wr(ADR_DH, 16'h0045);
      wr(ADR_CH, 16'h0012);
      wr(ADR_CL, 16'h0034);
      wr(ADR_SC, 16'h0000);
      wr(ADR_CMD, {8'h00, OP_FORMAT});
      rd(ADR_CMD);
      `CHK(d, 16'h0048)
      for (int i = 0; i < 256; i++)
         wr(ADR_DATA, 16'(i));
      wait_req();
      `CHK(media_req.is_format, 1'b1)
      `CHK(media_req.pattern, 8'hff)
      `CHK(media_req.lba, {20'h0, 4'h5, 8'h12, 8'h34, 8'h00})
      `CHK(media_req.count, 9'h100)
      wait_idle();
      `CHK(d, 16'h0050)
      test_end("format");
      tally_and_finish();
   end
endmodule
